// ---- emp_consts.svh ----
`ifndef EMP_CONSTS_SVH
`define EMP_CONSTS_SVH
// ----------------------------------------------------------------------
// Behaviour
// - 100 Mbps needs a 25 MHz bus clock; 2.5 MHz serves 10 Mbps only.
// - Transceiver clocks stay stopped while both clock-disable bits are set.
// - Transceiver bus address from register 1 is latched onto phy_addr_o when enable rises.
// - Clear autoneg_disable selects auto-negotiation; set means manual mode.
// - MII traffic is possible only after transceiver_enable is set, or in external transceiver mode.
// - Management clock is divided from the bus clock by the divisor field.
// - Buffer placement follows the buffer_space_map field of buffer_config.
// - Receiver rejects frames longer than max_rx_frame_length.
// - Six-byte station address is held in registers and filters receive.
// - Frame-type filter uses frame_type_match and frame_type_filter_ctl.
// - Address filter honours broadcast reject, conditional multicast, accept all.
// - MAC offers loopback, external transceiver mode and full duplex bits.
// - MAC core stays inactive until mac_core_enable is set.
// - Each interrupt source reaches the CPU only when its mask bit is set.
// - Software sets pause_request, then loads pause_duration for the frame.
// - Command 0x01 starts transmission, only while transmitter_active is clear.
// - Transmitter computes and appends the frame check sequence itself.
// - Device sets buffer done flag on a valid frame; software clears it.
// - While both receive buffer done flags are set, new frames are dropped.
// - Speed bit 1 selects 100 Mbps, 0 selects 10 Mbps in manual mode.
// ----------------------------------------------------------------------
`define EMP_A_CTLA 5'h00
`define EMP_A_CTLB 5'h01
`define EMP_A_MGMT 5'h02
`define EMP_A_BUFFER_CONFIG 5'h03
`define EMP_A_MAC0 5'h04
`define EMP_A_MAC1 5'h05
`define EMP_A_MAC2 5'h06
`define EMP_A_FRAME_TYPE_MATCH 5'h07
`define EMP_A_FRAME_TYPE_FILTER_CTL 5'h08
`define EMP_A_RECEIVE_CONTROL_STATUS 5'h09
`define EMP_A_NETWORK_CONTROL 5'h0A
`define EMP_A_INTERRUPT_MASK 5'h0B
`define EMP_A_INTERRUPT_EVENT 5'h0C
`define EMP_A_TX_SPECIAL_CONTROL_STATUS 5'h0D
`define EMP_A_PAUSE_DURATION 5'h0E
`define EMP_A_TRANSMIT_CONTROL_STATUS 5'h0F
`define EMP_A_TXLEN 5'h10
`define EMP_A_RXLENA 5'h11
`define EMP_A_RXLENB 5'h12
`define EMP_B_SLOW 0
`define EMP_B_FAST 1
`define EMP_B_AUTONEG_DISABLE 2
`define EMP_B_LED 3
`define EMP_B_TEN 4
`define EMP_B_SPD 5
`define EMP_B_DPX 6
`define EMP_B_CORE 0
`define EMP_B_MLB 1
`define EMP_B_EXT 2
`define EMP_B_FDX 3
`define EMP_B_BROADCAST_REJECT 0
`define EMP_B_CONDITIONAL_MULTICAST 1
`define EMP_B_ACCEPT_ALL_FRAMES 2
`define EMP_B_RX_FLOW_CONTROL_ENABLE 3
`define EMP_B_ETEN 0
`define EMP_B_ACT 2
`define EMP_F_MAP 15:13
`define EMP_F_MAX_RX_FRAME_LENGTH 10:0
`define EMP_M_CTLA 16'h007F
`define EMP_M_CTLB 16'h001F
`define EMP_M_MGMT 16'h000F
`define EMP_M_BUFFER_CONFIG 16'hE7FF
`define EMP_M_LOW4 16'h000F
`define EMP_M_EV 16'h0007
`define EMP_M_BIT0 16'h0001
`define EMP_M_LEN 16'h07FF
`define EMP_RST_CTLA 16'h0003
`define EMP_TXB_OFF 16'h0000
`define EMP_RXA_OFF 16'h0800
`define EMP_RXB_OFF 16'h1000
`define EMP_TRANSMIT_COMMAND_START 2'h1
`define EMP_PRE_NIB 4'h5
`define EMP_SFD_NIB 4'hD
`define EMP_PRE_LAST 11'h00F
`define EMP_FCS_LAST 11'h007
`define EMP_HDR_MIN 11'h00E
`define EMP_DA_LEN 11'h006
`define EMP_TYPE_HI 11'h00C
`define EMP_TYPE_LO 11'h00D
`define EMP_BCAST 8'hFF
`define EMP_CRC_INIT 32'hFFFFFFFF
`define EMP_CRC_POLY 32'hEDB88320
`define EMP_CRC_RES 32'hDEBB20E3
`define EMP_REF_KHZ 125000
`define EMP_FAST_KHZ 25000
`define EMP_SLOW_KHZ 2500
`endif

// ---- emp_pkg.sv ----
package emp_pkg;
    typedef enum logic [1:0] {tx_idle = 2'b00, tx_pre = 2'b01, tx_data = 2'b10,
        tx_fcs = 2'b11} emp_tx_st_t;
    typedef enum logic [1:0] {rx_idle = 2'b00, rx_pre = 2'b01, rx_data = 2'b10,
        rx_drop = 2'b11} emp_rx_st_t;
    typedef struct packed {logic en; logic [3:0] d;} emp_mii_tx_t;
    typedef struct packed {logic dv; logic er; logic [3:0] d;} emp_mii_rx_t;
endpackage

// ---- emp_crc.sv ----
`timescale 1ns/1ps
`include "emp_consts.svh"
module emp_crc
(
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic init_i,
    input wire logic en_i,
    input wire logic [7:0] data_i,
    output logic [31:0] crc_o
);
    logic [31:0] next_crc;

    // Reflected form, least significant bit first, as the bits leave the wire.
    always_comb
    begin
        next_crc = crc_o;
        for (int i = 0; i < 8; i++)
        begin
            if (next_crc[0] ^ data_i[i])
                next_crc = (next_crc >> 1) ^ `EMP_CRC_POLY;
            else
                next_crc = next_crc >> 1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i)
        if (!nrst_i)
            crc_o <= `EMP_CRC_INIT;
        else if (ce_i && init_i)
            crc_o <= `EMP_CRC_INIT;
        else if (ce_i && en_i)
            crc_o <= next_crc;
endmodule

// ---- emp_mac.sv ----
`timescale 1ns/1ps
`include "emp_consts.svh"
module emp_mac
    import emp_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic [4:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    output emp_mii_tx_t mii_tx_o,
    input wire emp_mii_rx_t mii_rx_i,
    output logic [15:0] mem_raddr_o,
    input wire logic [7:0] mem_rdata_i,
    output logic [15:0] mem_waddr_o,
    output logic [7:0] mem_wdata_o,
    output logic mem_we_o,
    output logic mdc_o,
    output logic phy_clk_run_o,
    output logic phy_enable_o,
    output logic [4:0] phy_addr_o,
    output logic phy_autoneg_o,
    output logic phy_speed100_o,
    output logic phy_duplex_o,
    output logic led_en_o,
    output logic ext_phy_o,
    output logic full_duplex_o,
    output logic rx_flow_en_o,
    output logic pause_req_o,
    output logic [15:0] pause_time_o,
    output logic bus_100_ok_o,
    output logic irq_o
);
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [15:0] ctl_a, ctl_b, mgmt, buf_cfg, mac0, mac1, mac2, frame_type_match;
    logic [15:0] frame_type_filter_ctl, receive_control_status, network_control, interrupt_mask, txs, pause_duration, txlen;
    logic [2:0] ev, ev_set, ev_clr;
    logic [10:0] len_a, len_b;
    logic core_en, mii_ok, rx_ok, start_tx, ten_q;
    logic [15:0] base;
    emp_tx_st_t tx_st;
    emp_rx_st_t rx_st;

    assign core_en = network_control[`EMP_B_CORE];
    // Traffic to the internal transceiver is gated until it is enabled.
    assign mii_ok = ctl_a[`EMP_B_TEN] | network_control[`EMP_B_EXT];
    assign rx_ok = core_en & mii_ok;
    assign base = {buf_cfg[`EMP_F_MAP], 13'h0000};

    always_ff @(posedge ref_clk_i or negedge nrst_i)
        if (!nrst_i)
        begin
            ctl_a <= `EMP_RST_CTLA;
            ctl_b <= '0;
            mgmt <= '0;
            buf_cfg <= '0;
            mac0 <= '0;
            mac1 <= '0;
            mac2 <= '0;
            frame_type_match <= '0;
            frame_type_filter_ctl <= '0;
            receive_control_status <= '0;
            network_control <= '0;
            interrupt_mask <= '0;
            txs <= '0;
            pause_duration <= '0;
            txlen <= '0;
        end
        else if (ce_i && wr_i)
        begin
            case (addr_i)
                `EMP_A_CTLA: ctl_a <= wdata_i & `EMP_M_CTLA;
                `EMP_A_CTLB: ctl_b <= wdata_i & `EMP_M_CTLB;
                `EMP_A_MGMT: mgmt <= wdata_i & `EMP_M_MGMT;
                `EMP_A_BUFFER_CONFIG: buf_cfg <= wdata_i & `EMP_M_BUFFER_CONFIG;
                `EMP_A_MAC0: mac0 <= wdata_i;
                `EMP_A_MAC1: mac1 <= wdata_i;
                `EMP_A_MAC2: mac2 <= wdata_i;
                `EMP_A_FRAME_TYPE_MATCH: frame_type_match <= wdata_i;
                `EMP_A_FRAME_TYPE_FILTER_CTL: frame_type_filter_ctl <= wdata_i & `EMP_M_BIT0;
                `EMP_A_RECEIVE_CONTROL_STATUS: receive_control_status <= wdata_i & `EMP_M_LOW4;
                `EMP_A_NETWORK_CONTROL: network_control <= wdata_i & `EMP_M_LOW4;
                `EMP_A_INTERRUPT_MASK: interrupt_mask <= wdata_i & `EMP_M_EV;
                `EMP_A_TX_SPECIAL_CONTROL_STATUS: txs <= wdata_i & `EMP_M_BIT0;
                `EMP_A_PAUSE_DURATION: pause_duration <= wdata_i;
                `EMP_A_TXLEN: txlen <= wdata_i & `EMP_M_LEN;
                default: ;
            endcase
        end

    always_ff @(posedge ref_clk_i or negedge nrst_i)
        if (!nrst_i)
            rdata_o <= '0;
        else if (ce_i)
        begin
            rdata_o <= '0;
            if (rd_i)
            begin
                case (addr_i)
                    `EMP_A_CTLA: rdata_o <= ctl_a;
                    `EMP_A_CTLB: rdata_o <= ctl_b;
                    `EMP_A_MGMT: rdata_o <= mgmt;
                    `EMP_A_BUFFER_CONFIG: rdata_o <= buf_cfg;
                    `EMP_A_MAC0: rdata_o <= mac0;
                    `EMP_A_MAC1: rdata_o <= mac1;
                    `EMP_A_MAC2: rdata_o <= mac2;
                    `EMP_A_FRAME_TYPE_MATCH: rdata_o <= frame_type_match;
                    `EMP_A_FRAME_TYPE_FILTER_CTL: rdata_o <= frame_type_filter_ctl;
                    `EMP_A_RECEIVE_CONTROL_STATUS: rdata_o <= receive_control_status;
                    `EMP_A_NETWORK_CONTROL: rdata_o <= network_control;
                    `EMP_A_INTERRUPT_MASK: rdata_o <= interrupt_mask;
                    `EMP_A_INTERRUPT_EVENT: rdata_o <= {13'h0000, ev};
                    `EMP_A_TX_SPECIAL_CONTROL_STATUS: rdata_o <= txs;
                    `EMP_A_PAUSE_DURATION: rdata_o <= pause_duration;
                    `EMP_A_TRANSMIT_CONTROL_STATUS: rdata_o <= 16'(tx_st != tx_idle) << `EMP_B_ACT;
                    `EMP_A_TXLEN: rdata_o <= txlen;
                    `EMP_A_RXLENA: rdata_o <= {5'h00, len_a};
                    `EMP_A_RXLENB: rdata_o <= {5'h00, len_b};
                    default: rdata_o <= '0;
                endcase
            end
        end

    // ------------------------------------------------------------------
    // Transceiver control
    // ------------------------------------------------------------------
    // The address is taken once, on the enable edge, so later writes to it
    // do not disturb a running transceiver.
    always_ff @(posedge ref_clk_i or negedge nrst_i)
        if (!nrst_i)
        begin
            ten_q <= 1'b0;
            phy_addr_o <= '0;
        end
        else if (ce_i)
        begin
            ten_q <= ctl_a[`EMP_B_TEN];
            if (ctl_a[`EMP_B_TEN] && !ten_q)
                phy_addr_o <= ctl_b[4:0];
        end

    assign phy_clk_run_o = !ctl_a[`EMP_B_SLOW] && !ctl_a[`EMP_B_FAST];
    assign phy_enable_o = ctl_a[`EMP_B_TEN];
    assign phy_autoneg_o = !ctl_a[`EMP_B_AUTONEG_DISABLE];
    assign phy_speed100_o = ctl_a[`EMP_B_AUTONEG_DISABLE] & ctl_a[`EMP_B_SPD];
    assign phy_duplex_o = ctl_a[`EMP_B_AUTONEG_DISABLE] & ctl_a[`EMP_B_DPX];
    assign led_en_o = ctl_a[`EMP_B_LED];
    assign ext_phy_o = network_control[`EMP_B_EXT];
    assign full_duplex_o = network_control[`EMP_B_FDX];
    assign rx_flow_en_o = receive_control_status[`EMP_B_RX_FLOW_CONTROL_ENABLE];
    assign pause_req_o = txs[0];
    assign pause_time_o = pause_duration;
    assign bus_100_ok_o = (`EMP_REF_KHZ >= `EMP_FAST_KHZ);

    logic [3:0] mdc_cnt;
    always_ff @(posedge ref_clk_i or negedge nrst_i)
        if (!nrst_i)
        begin
            mdc_cnt <= '0;
            mdc_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (mdc_cnt >= mgmt[3:0])
            begin
                mdc_cnt <= '0;
                mdc_o <= !mdc_o;
            end
            else
                mdc_cnt <= mdc_cnt + 4'h1;
        end

    // ------------------------------------------------------------------
    // Transmit
    // ------------------------------------------------------------------
    logic [10:0] tx_cnt;
    logic tx_nib, tx_en_c, tx_last;
    logic [7:0] tx_byte;
    logic [3:0] tx_d;
    logic [31:0] tx_crc, fcs_sh;

    assign start_tx = wr_i && addr_i == `EMP_A_TRANSMIT_CONTROL_STATUS && wdata_i[1:0] == `EMP_TRANSMIT_COMMAND_START
        && core_en && mii_ok;
    assign tx_last = 11'(tx_cnt + 11'h001) >= txlen[10:0];
    assign fcs_sh = ~tx_crc >> {tx_cnt[2:0], 2'b00};

    always_comb
    begin
        tx_en_c = tx_st != tx_idle;
        case (tx_st)
            tx_pre: tx_d = (tx_cnt == `EMP_PRE_LAST) ? `EMP_SFD_NIB : `EMP_PRE_NIB;
            tx_data: tx_d = tx_nib ? tx_byte[7:4] : tx_byte[3:0];
            tx_fcs: tx_d = fcs_sh[3:0];
            default: tx_d = `EMP_PRE_NIB;
        endcase
    end

    // A start while busy is ignored; the busy status lets software see why.
    always_ff @(posedge ref_clk_i or negedge nrst_i)
        if (!nrst_i)
        begin
            tx_st <= tx_idle;
            tx_cnt <= '0;
            tx_nib <= 1'b0;
            tx_byte <= '0;
            mem_raddr_o <= '0;
        end
        else if (ce_i)
        begin
            case (tx_st)
                tx_idle:
                    if (start_tx)
                    begin
                        tx_st <= tx_pre;
                        tx_cnt <= '0;
                        mem_raddr_o <= base + `EMP_TXB_OFF;
                    end
                tx_pre:
                    if (tx_cnt == `EMP_PRE_LAST)
                    begin
                        tx_byte <= mem_rdata_i;
                        mem_raddr_o <= mem_raddr_o + 16'h0001;
                        tx_cnt <= '0;
                        tx_nib <= 1'b0;
                        tx_st <= tx_data;
                    end
                    else
                        tx_cnt <= tx_cnt + 11'h001;
                tx_data:
                    if (!tx_nib)
                        tx_nib <= 1'b1;
                    else
                    begin
                        tx_nib <= 1'b0;
                        if (tx_last)
                        begin
                            tx_st <= tx_fcs;
                            tx_cnt <= '0;
                        end
                        else
                        begin
                            tx_byte <= mem_rdata_i;
                            mem_raddr_o <= mem_raddr_o + 16'h0001;
                            tx_cnt <= tx_cnt + 11'h001;
                        end
                    end
                tx_fcs:
                    if (tx_cnt == `EMP_FCS_LAST)
                        tx_st <= tx_idle;
                    else
                        tx_cnt <= tx_cnt + 11'h001;
                default: tx_st <= tx_idle;
            endcase
        end

    always_ff @(posedge ref_clk_i or negedge nrst_i)
        if (!nrst_i)
            mii_tx_o <= '0;
        else if (ce_i)
        begin
            mii_tx_o.en <= tx_en_c & core_en & mii_ok;
            mii_tx_o.d <= tx_d;
        end

    emp_crc u_tx_crc
    (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .init_i(tx_st == tx_idle),
        .en_i(tx_st == tx_data && !tx_nib),
        .data_i(tx_byte),
        .crc_o(tx_crc)
    );

    // ------------------------------------------------------------------
    // Receive
    // ------------------------------------------------------------------
    emp_mii_rx_t rx;
    logic [10:0] rx_cnt;
    logic rx_nib, rx_sel, rx_bad, da_hit, bc, mc, ty_hit, addr_ok, accept;
    logic [3:0] rx_lo;
    logic [7:0] rx_byte, sta_byte, ety_byte;
    logic [47:0] mac_sh;
    logic [31:0] rx_crc;

    // Loopback feeds the registered transmit nibbles straight back.
    assign rx = network_control[`EMP_B_MLB] ? {mii_tx_o.en, 1'b0, mii_tx_o.d} : mii_rx_i;
    assign rx_byte = {rx.d, rx_lo};
    assign mac_sh = {mac0, mac1, mac2} << {rx_cnt[2:0], 3'b000};
    assign sta_byte = mac_sh[47:40];
    assign ety_byte = rx_cnt[0] ? frame_type_match[7:0] : frame_type_match[15:8];
    assign addr_ok = receive_control_status[`EMP_B_ACCEPT_ALL_FRAMES] | (bc ? !receive_control_status[`EMP_B_BROADCAST_REJECT]
        : (mc ? receive_control_status[`EMP_B_CONDITIONAL_MULTICAST] : da_hit));
    assign accept = rx_st == rx_data && !rx.dv && !rx_bad && !rx_nib
        && rx_cnt >= `EMP_HDR_MIN && rx_crc == `EMP_CRC_RES && addr_ok
        && (!frame_type_filter_ctl[`EMP_B_ETEN] || ty_hit);

    always_ff @(posedge ref_clk_i or negedge nrst_i)
        if (!nrst_i)
        begin
            rx_st <= rx_idle;
            {rx_cnt, rx_nib, rx_lo, rx_sel, rx_bad} <= '0;
            {da_hit, bc, mc, ty_hit} <= '0;
            {mem_waddr_o, mem_wdata_o, mem_we_o} <= '0;
        end
        else if (ce_i)
        begin
            mem_we_o <= 1'b0;
            case (rx_st)
                rx_idle:
                    if (rx.dv && rx_ok)
                    begin
                        if (ev[0] && ev[1])
                            rx_st <= rx_drop;
                        else
                        begin
                            rx_st <= rx_pre;
                            rx_sel <= ev[0];
                        end
                    end
                rx_pre:
                    if (!rx.dv)
                        rx_st <= rx_idle;
                    else if (rx.d == `EMP_SFD_NIB)
                    begin
                        rx_st <= rx_data;
                        {rx_cnt, rx_nib, rx_bad, mc} <= '0;
                        {da_hit, bc, ty_hit} <= 3'h7;
                    end
                rx_data:
                    if (!rx.dv)
                        rx_st <= rx_idle;
                    else
                    begin
                        if (rx.er)
                            rx_bad <= 1'b1;
                        rx_nib <= !rx_nib;
                        if (!rx_nib)
                            rx_lo <= rx.d;
                        else
                        begin
                            if (rx_cnt >= buf_cfg[`EMP_F_MAX_RX_FRAME_LENGTH])
                                rx_bad <= 1'b1;
                            else
                            begin
                                mem_we_o <= 1'b1;
                                mem_waddr_o <= base + (rx_sel ? `EMP_RXB_OFF : `EMP_RXA_OFF)
                                    + {5'h00, rx_cnt};
                                mem_wdata_o <= rx_byte;
                            end
                            if (rx_cnt < `EMP_DA_LEN)
                            begin
                                da_hit <= da_hit & (rx_byte == sta_byte);
                                bc <= bc & (rx_byte == `EMP_BCAST);
                            end
                            if (rx_cnt == '0)
                                mc <= rx_byte[0];
                            if (rx_cnt == `EMP_TYPE_HI || rx_cnt == `EMP_TYPE_LO)
                                ty_hit <= ty_hit & (rx_byte == ety_byte);
                            if (!rx_bad)
                                rx_cnt <= rx_cnt + 11'h001;
                        end
                    end
                rx_drop:
                    if (!rx.dv)
                        rx_st <= rx_idle;
                default: rx_st <= rx_idle;
            endcase
        end

    emp_crc u_rx_crc
    (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .init_i(rx_st == rx_pre),
        .en_i(rx_st == rx_data && rx.dv && rx_nib),
        .data_i(rx_byte),
        .crc_o(rx_crc)
    );

    // ------------------------------------------------------------------
    // Events
    // ------------------------------------------------------------------
    assign ev_set = {tx_st == tx_fcs && tx_cnt == `EMP_FCS_LAST, accept & rx_sel,
        accept & !rx_sel};
    assign ev_clr = (wr_i && addr_i == `EMP_A_INTERRUPT_EVENT) ? wdata_i[2:0] : 3'h0;

    // A set in the clearing cycle wins, so no completed frame is lost.
    always_ff @(posedge ref_clk_i or negedge nrst_i)
        if (!nrst_i)
        begin
            ev <= '0;
            len_a <= '0;
            len_b <= '0;
        end
        else if (ce_i)
        begin
            ev <= (ev & ~ev_clr) | ev_set;
            if (accept && !rx_sel)
                len_a <= rx_cnt;
            if (accept && rx_sel)
                len_b <= rx_cnt;
        end

    assign irq_o = |(ev & interrupt_mask[2:0]);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_start;
        ce_i && tx_st == tx_idle && start_tx;
    endsequence
    sequence s_fcs_end;
        ce_i && tx_st == tx_fcs && tx_cnt == `EMP_FCS_LAST;
    endsequence

    a_tx_start_go: assert property (s_start |=> tx_st == tx_pre)
        else $error("start command not taken");
    a_tx_fcs_end: assert property (s_fcs_end |=> tx_st == tx_idle && ev[2])
        else $error("frame check tail did not finish");
    a_rx_full_drop: assert property (ce_i && rx_st == rx_idle && rx.dv && rx_ok
        && ev[0] && ev[1] |=> rx_st == rx_drop)
        else $error("frame taken while both buffers full");
    a_done_flag_hold: assert property (ev[0] && !(ce_i && ev_clr[0]) |=> ev[0])
        else $error("buffer done flag lost");
    a_irq_masked: assert property (interrupt_mask[2:0] == 3'h0 |-> !irq_o)
        else $error("interrupt through a closed mask");
    a_addr_latch: assert property (ce_i && ctl_a[`EMP_B_TEN] && !ten_q
        |=> phy_addr_o == $past(ctl_b[4:0]))
        else $error("transceiver address not latched");
    a_clk_stopped: assert property (ctl_a[`EMP_B_SLOW] && ctl_a[`EMP_B_FAST]
        |-> !phy_clk_run_o)
        else $error("transceiver clocks running while disabled");
    a_core_gate: assert property (ce_i && !(core_en && mii_ok) |=> !mii_tx_o.en)
        else $error("transmit while core or transceiver off");
    a_rx_too_long: assert property (ce_i && rx_st == rx_data && rx.dv && rx_nib
        && rx_cnt >= buf_cfg[`EMP_F_MAX_RX_FRAME_LENGTH] |=> rx_bad ##1 !accept)
        else $error("over-length frame not rejected");
endmodule

// ---- emp_phy_model.sv ----
`timescale 1ns/1ps
module emp_phy_model
    import emp_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic [15:0] mem_raddr_i,
    output logic [7:0] mem_rdata_o,
    output emp_mii_rx_t mii_rx_o
);
    // Receive side stays silent, so no frame competes with transmit checks.
    assign mii_rx_o = '0;
    // Buffer byte depends on its address and lags it by one cycle, as a sync RAM.
    always_ff @(posedge ref_clk_i)
        mem_rdata_o <= mem_raddr_i[7:0] ^ 8'hA5;
endmodule

// ---- ethernet_mac_phy_bringup_tb_top.sv ----
`timescale 1ns/1ps
module ethernet_mac_phy_bringup_tb_top
    import emp_pkg::*;
;
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata, raddr;
    logic [15:0] seed = 16'h452A;
    logic [7:0] rbyte;
    logic [4:0] paddr;
    logic run, aneg, spd, irq, rfc, full_duplex_select;
    logic ce = 1'b1;
    emp_mii_tx_t tx;
    emp_mii_rx_t rxm;
    int miscompares = 0;
    int comparisons = 0;
    logic [3:0] q[$];
    logic [3:0] e[$];
    emp_mac dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(ce), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .mii_tx_o(tx),
        .mii_rx_i(rxm), .mem_raddr_o(raddr), .mem_rdata_i(rbyte), .mem_waddr_o(),
        .mem_wdata_o(), .mem_we_o(), .mdc_o(), .phy_clk_run_o(run), .phy_enable_o(),
        .phy_addr_o(paddr), .phy_autoneg_o(aneg), .phy_speed100_o(spd), .phy_duplex_o(),
        .led_en_o(), .ext_phy_o(), .full_duplex_o(full_duplex_select), .rx_flow_en_o(rfc), .pause_req_o(),
        .pause_time_o(), .bus_100_ok_o(), .irq_o(irq));
    emp_phy_model phy (.ref_clk_i(ref_clk_i), .mem_raddr_i(raddr), .mem_rdata_o(rbyte),
        .mii_rx_o(rxm));
    // ------------------------------------------------------------
    // Bus tasks and checks
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [15:0] g, input logic [15:0] x);
        comparisons++;
        if (g !== x)
        begin
            miscompares++;
            $display("MISMATCH %0t got %h want %h", $time, g, x);
        end
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk_i);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] x);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk_i);
        rd <= 1'b0;
        #1;
        chk(rdata, x);
    endtask
    // A second start one cycle later lands while busy and must change nothing.
    task automatic tx_run(input int n, input logic go);
        logic [31:0] c;
        logic [7:0] b;
        wr_reg(5'h10, 16'(n));
        wr_reg(5'h0F, 16'h0001);
        wr_reg(5'h0F, 16'h0001);
        q = {};
        e = {};
        for (int k = 0; k < 200 && (q.size() == 0 || tx.en); k++)
        begin
            if (tx.en === 1'b1)
                q.push_back(tx.d);
            @(posedge ref_clk_i);
            #1;
        end
        c = 32'hFFFFFFFF;
        for (int k = 0; k < 16; k++)
            e.push_back(k == 15 ? 4'hD : 4'h5);
        for (int k = 0; k < n; k++)
        begin
            b = 8'(k) ^ 8'hA5;
            e.push_back(b[3:0]);
            e.push_back(b[7:4]);
            c ^= {24'h0, b};
            repeat (8) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
        end
        for (int k = 0; k < 8; k++)
            e.push_back(~c[4 * k +: 4]);
        chk(16'(q.size()), go ? 16'(e.size()) : 16'h0000);
        for (int k = 0; go && k < e.size(); k++)
            chk(16'(q[k]), 16'(e[k]));
        repeat (3) @(posedge ref_clk_i);
        #1;
        $display("transmit test done, %0d bytes", n);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    initial
    begin
        #100000;
        miscompares++;
        wrap_up();
    end
    initial
    begin
        repeat (20) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_chk(5'h00, 16'h0003);
        chk(run, 1'b0);
        chk(aneg, 1'b1);
        rd_chk(5'h1F, 16'h0000);
        seed = lfsr(seed);
        wr_reg(5'h01, {11'h000, seed[4:0]});
        wr_reg(5'h0A, 16'h0001);
        tx_run(3, 1'b0);
        wr_reg(5'h00, 16'h0037);
        wr_reg(5'h01, ~{11'h000, seed[4:0]});
        chk(paddr, seed[4:0]);
        chk(spd, 1'b1);
        chk(aneg, 1'b0);
        wr_reg(5'h00, 16'h0014);
        chk(run, 1'b1);
        chk(spd, 1'b0);
        wr_reg(5'h0A, 16'h0000);
        tx_run(2, 1'b0);
        wr_reg(5'h0A, 16'h0001);
        tx_run(int'(seed[3:0]) + 1, 1'b1);
        rd_chk(5'h0C, 16'h0004);
        chk(irq, 1'b0);
        wr_reg(5'h0B, 16'h0004);
        chk(irq, 1'b1);
        wr_reg(5'h0C, 16'h0004);
        chk(irq, 1'b0);
        ce <= 1'b0;
        wr_reg(5'h0E, 16'h1234);
        ce <= 1'b1;
        rd_chk(5'h0E, 16'h0000);
        wr_reg(5'h0E, 16'h1234);
        rd_chk(5'h0E, 16'h1234);
        wr_reg(5'h03, 16'h0014);
        wr_reg(5'h07, 16'hA9A8);
        wr_reg(5'h08, 16'h0001);
        wr_reg(5'h09, 16'h000A);
        chk(rfc, 1'b1);
        wr_reg(5'h0A, 16'h0003);
        // The first looped byte is odd, so only conditional multicast lets frames in.
        tx_run(14, 1'b1);
        rd_chk(5'h0C, 16'h0005);
        rd_chk(5'h11, 16'h0012);
        tx_run(17, 1'b1);
        rd_chk(5'h0C, 16'h0005);
        tx_run(16, 1'b1);
        rd_chk(5'h0C, 16'h0007);
        rd_chk(5'h12, 16'h0014);
        tx_run(14, 1'b1);
        rd_chk(5'h12, 16'h0014);
        wr_reg(5'h0C, 16'h0001);
        rd_chk(5'h0C, 16'h0006);
        wr_reg(5'h0A, 16'h0009);
        chk(full_duplex_select, 1'b1);
        $display("receive loopback test done");
        wrap_up();
    end
endmodule
